// [flash_pkg.sv]
/*
  Shared constants and types of the serial flash read command path.
  Assumes one 50 MHz system clock; all link pins arrive asynchronously.
*/
package flash_pkg;

  // ****************************************
  // Array geometry
  // ****************************************
  localparam int unsigned PAGE_COUNT = 512;
  localparam int unsigned PAGE_BYTES = 264;
  localparam int unsigned ARRAY_BYTES = PAGE_COUNT * PAGE_BYTES;
  localparam logic [17:0] PAGE_STRIDE = 18'h00108;
  localparam logic [8:0] LAST_BYTE = 9'h107;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned FIFO_DEPTH = 4;

  // ****************************************
  // Opcodes and last header bit positions
  // ****************************************
  localparam logic [7:0] OP_PAGE_READ = 8'h52;
  localparam logic [7:0] OP_PAGE_COPY = 8'h53;
  localparam logic [7:0] OP_BUF_READ = 8'h54;
  localparam logic [7:0] OP_STATUS = 8'h57;
  localparam logic [7:0] OP_COMPARE = 8'h60;
  localparam logic [6:0] LAST_OPCODE_BIT = 7'h07;
  localparam logic [6:0] LAST_ADDR_BIT = 7'h1F;
  localparam logic [6:0] LAST_BUF_DUMMY = 7'h27;
  localparam logic [6:0] LAST_PAGE_DUMMY = 7'h3F;
  localparam logic [6:0] BIT_CNT_MAX = 7'h7F;
  localparam int unsigned PAGE_LSB = 9;
  localparam int unsigned OFFSET_LSB = 0;

  // ****************************************
  // Status byte layout
  // ****************************************
  localparam int unsigned STAT_READY_BIT = 7;
  localparam int unsigned STAT_CMP_BIT = 6;
  // Density field value is arbitrary
  localparam logic [3:0] DENSITY_CODE = 4'h3;
  localparam logic [1:0] STAT_LOW_BITS = 2'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned PAGE_COPY_TIME_NS = 120000;
  localparam int unsigned PAGE_COPY_CYCLES = PAGE_COPY_TIME_NS / CLK_PERIOD_NS;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } link_t;

  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_COPY = 2'b01,
    OP_CHECK = 2'b10,
    OP_SETTLE = 2'b11
  } op_state_t;

  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_MAIN = 2'b01,
    SRC_BUF = 2'b10,
    SRC_STATUS = 2'b11
  } data_src_t;

endpackage

// [serial_flash_read_command_path.sv]
/*
  Read side of a page-organised serial flash: framing, page read,
  buffer read, page copy, page compare and status read.
  Assumes a 50 MHz i_clk much faster than the link clock, and a
  preload port that fills the main array before use.
*/
// Notes on behaviour
// - Accept link clock modes 0 and 3
// - Chip select fall starts opcode then address
// - Sample input only while chip select low
// - Everything travels most significant bit first
// - Main array: 512 pages of 264 bytes
// - Separate 264 byte page buffer
// - Page read: 52H, 24 address, 32 dummy
// - Address: six reserved, page, byte offset
// - Page read leaves buffer untouched
// - After dummies each clock shifts data out
// - Page read wraps within same page
// - Chip select rise ends read, releases output
// - Buffer read: 54H, 15 dummy, address, 8 dummy
// - Buffer read wraps to byte zero
// - Page copy: 53H, reserved, page, dummies
// - Copy starts on closing chip select rise
// - Status readable during copy, shows progress
// - Compare: 60H, reserved, page, dummies
// - Compare all bytes, busy meanwhile
// - Compare outcome lands in status bit 6
// - Status read 57H, eight bits follow
// - Status repeats with fresh contents
`timescale 1ns/1ns

module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_flush,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign o_in_ready = (cnt_q != FULL_CNT);
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rd_q];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (i_flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST_IDX) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST_IDX) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

module serial_flash_read_command_path #(
  parameter int unsigned COPY_CYCLES = flash_pkg::PAGE_COPY_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Serial link
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe_n,
  output logic o_ready,
  // Main array preload
  input wire logic i_load_valid,
  input wire logic [17:0] i_load_addr,
  input wire logic [7:0] i_load_data
);
  // ****************************************
  // Memories
  // ****************************************
  logic [7:0] main_mem [flash_pkg::ARRAY_BYTES];
  logic [7:0] buf_mem [flash_pkg::PAGE_BYTES];

  function automatic logic [17:0] arr_idx(input logic [8:0] page,
                                          input logic [8:0] off);
    arr_idx = 18'(page) * flash_pkg::PAGE_STRIDE + 18'(off);
  endfunction

  // ****************************************
  // Link synchroniser and edge detection
  // ****************************************
  flash_pkg::link_t link_in;
  flash_pkg::link_t meta_q;
  flash_pkg::link_t sync_q;
  flash_pkg::link_t prev_q;
  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;

  assign link_in = '{cs_n: i_cs_n, sck: i_sck, si: i_si};

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= 3'h4;
      sync_q <= 3'h4;
      prev_q <= 3'h4;
    end else begin
      meta_q <= link_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edges are found on the sampled clock, so either idle level works
  assign cs_low = !sync_q.cs_n;
  assign cs_fall = cs_low && prev_q.cs_n;
  assign cs_rise = sync_q.cs_n && !prev_q.cs_n;
  assign sck_rise = cs_low && sync_q.sck && !prev_q.sck;
  assign sck_fall = cs_low && !sync_q.sck && prev_q.sck;

  // ****************************************
  // Command shifter
  // ****************************************
  logic [6:0] bit_cnt_q;
  logic [31:0] shift_q;
  logic [31:0] full_w;
  logic [7:0] opcode_q;
  logic [8:0] page_q;
  logic addr_done_q;
  logic is_read;

  assign full_w = {shift_q[30:0], sync_q.si};
  assign is_read = (opcode_q == flash_pkg::OP_PAGE_READ) ||
                   (opcode_q == flash_pkg::OP_BUF_READ);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bit_cnt_q <= '0;
      shift_q <= '0;
    end else if (cs_fall) begin
      bit_cnt_q <= '0;
    end else if (sck_rise) begin
      shift_q <= full_w;
      if (bit_cnt_q != flash_pkg::BIT_CNT_MAX) begin
        bit_cnt_q <= bit_cnt_q + 7'h01;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      opcode_q <= '0;
      page_q <= '0;
      addr_done_q <= 1'b0;
    end else if (cs_fall) begin
      opcode_q <= '0;
      addr_done_q <= 1'b0;
    end else if (sck_rise) begin
      if (bit_cnt_q == flash_pkg::LAST_OPCODE_BIT) begin
        opcode_q <= full_w[7:0];
      end
      if (bit_cnt_q == flash_pkg::LAST_ADDR_BIT) begin
        page_q <= full_w[flash_pkg::PAGE_LSB +: 9];
        addr_done_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Data phase selection
  // ****************************************
  flash_pkg::data_src_t src_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      src_q <= flash_pkg::SRC_NONE;
    end else if (cs_fall || cs_rise) begin
      src_q <= flash_pkg::SRC_NONE;
    end else if (sck_rise) begin
      if (bit_cnt_q == flash_pkg::LAST_OPCODE_BIT &&
          full_w[7:0] == flash_pkg::OP_STATUS) begin
        src_q <= flash_pkg::SRC_STATUS;
      end else if (bit_cnt_q == flash_pkg::LAST_BUF_DUMMY &&
                   opcode_q == flash_pkg::OP_BUF_READ) begin
        src_q <= flash_pkg::SRC_BUF;
      end else if (bit_cnt_q == flash_pkg::LAST_PAGE_DUMMY &&
                   opcode_q == flash_pkg::OP_PAGE_READ) begin
        src_q <= flash_pkg::SRC_MAIN;
      end
    end
  end

  // ****************************************
  // Read fetch into the byte FIFO
  // ****************************************
  logic fetch_en_q;
  logic fetch_main_q;
  logic [8:0] ptr_q;
  logic [8:0] fpage_q;
  logic rd_valid_q;
  logic [7:0] rd_data_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_pop;
  logic issue;

  // Prefetch runs during the dummy bits so the first byte is waiting
  assign issue = fetch_en_q && (!rd_valid_q || fifo_in_ready);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fetch_en_q <= 1'b0;
      fetch_main_q <= 1'b0;
      ptr_q <= '0;
      fpage_q <= '0;
    end else if (cs_rise || cs_fall) begin
      fetch_en_q <= 1'b0;
    end else if (sck_rise && bit_cnt_q == flash_pkg::LAST_ADDR_BIT && is_read) begin
      fetch_en_q <= 1'b1;
      fetch_main_q <= (opcode_q == flash_pkg::OP_PAGE_READ);
      fpage_q <= full_w[flash_pkg::PAGE_LSB +: 9];
      ptr_q <= full_w[flash_pkg::OFFSET_LSB +: 9];
    end else if (issue) begin
      ptr_q <= (ptr_q == flash_pkg::LAST_BYTE) ? '0 : ptr_q + 9'h001;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
    end else if (cs_rise || cs_fall) begin
      rd_valid_q <= 1'b0;
    end else if (issue) begin
      rd_valid_q <= 1'b1;
      // Main array read bypasses the buffer entirely
      rd_data_q <= fetch_main_q ? main_mem[arr_idx(fpage_q, ptr_q)] : buf_mem[ptr_q];
    end else if (fifo_in_ready) begin
      rd_valid_q <= 1'b0;
    end
  end

  byte_fifo #(
    .WIDTH(flash_pkg::BYTE_W),
    .DEPTH(flash_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_flush(cs_rise || cs_fall),
    .i_in_valid(rd_valid_q),
    .i_in_data(rd_data_q),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_data),
    .i_out_ready(fifo_pop)
  );

  // ****************************************
  // Output shifter
  // ****************************************
  logic [2:0] out_cnt_q;
  logic [7:0] out_sh_q;
  logic so_q;
  logic oe_n_q;
  logic [7:0] status_w;
  logic [7:0] next_byte;
  logic cmp_q;
  flash_pkg::op_state_t op_q;

  assign status_w = {op_q == flash_pkg::OP_IDLE, cmp_q,
                     flash_pkg::DENSITY_CODE, flash_pkg::STAT_LOW_BITS};
  assign next_byte = (src_q == flash_pkg::SRC_STATUS) ? status_w : fifo_out_data;
  assign fifo_pop = sck_fall && out_cnt_q == 3'h0 &&
                    (src_q == flash_pkg::SRC_MAIN || src_q == flash_pkg::SRC_BUF);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      out_cnt_q <= '0;
      out_sh_q <= '0;
      so_q <= 1'b0;
    end else if (cs_fall) begin
      out_cnt_q <= '0;
    end else if (sck_fall && src_q != flash_pkg::SRC_NONE) begin
      out_cnt_q <= out_cnt_q + 3'h1;
      if (out_cnt_q == 3'h0) begin
        // Status is sampled afresh at each pass
        so_q <= next_byte[7];
        out_sh_q <= {next_byte[6:0], 1'b0};
      end else begin
        so_q <= out_sh_q[7];
        out_sh_q <= {out_sh_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= !(cs_low && !cs_rise && src_q != flash_pkg::SRC_NONE);
    end
  end

  assign o_so = so_q;
  assign o_so_oe_n = oe_n_q;

  // ****************************************
  // Self-timed copy and compare
  // ****************************************
  logic start;
  logic [8:0] walk_q;
  logic [8:0] op_page_q;
  logic [15:0] timer_q;
  logic mismatch_q;
  logic is_check_q;
  logic [7:0] main_byte;

  // A busy device refuses a new copy or compare
  assign start = cs_rise && addr_done_q && op_q == flash_pkg::OP_IDLE &&
                 (opcode_q == flash_pkg::OP_PAGE_COPY ||
                  opcode_q == flash_pkg::OP_COMPARE);
  assign main_byte = main_mem[arr_idx(op_page_q, walk_q)];

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      op_q <= flash_pkg::OP_IDLE;
      walk_q <= '0;
      op_page_q <= '0;
      timer_q <= '0;
      is_check_q <= 1'b0;
    end else begin
      case (op_q)
        flash_pkg::OP_IDLE: begin
          if (start) begin
            op_page_q <= page_q;
            walk_q <= '0;
            timer_q <= '0;
            is_check_q <= (opcode_q == flash_pkg::OP_COMPARE);
            op_q <= (opcode_q == flash_pkg::OP_COMPARE) ?
                    flash_pkg::OP_CHECK : flash_pkg::OP_COPY;
          end
        end
        flash_pkg::OP_COPY, flash_pkg::OP_CHECK: begin
          timer_q <= timer_q + 16'h0001;
          walk_q <= walk_q + 9'h001;
          if (walk_q == flash_pkg::LAST_BYTE) begin
            op_q <= flash_pkg::OP_SETTLE;
          end
        end
        flash_pkg::OP_SETTLE: begin
          timer_q <= timer_q + 16'h0001;
          if (timer_q >= 16'(COPY_CYCLES - 1)) begin
            op_q <= flash_pkg::OP_IDLE;
          end
        end
        default: begin
          op_q <= flash_pkg::OP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (op_q == flash_pkg::OP_COPY) begin
      buf_mem[walk_q] <= main_byte;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_load_valid) begin
      main_mem[i_load_addr] <= i_load_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mismatch_q <= 1'b0;
      cmp_q <= 1'b0;
    end else if (start) begin
      mismatch_q <= 1'b0;
    end else if (op_q == flash_pkg::OP_CHECK) begin
      if (main_byte != buf_mem[walk_q]) begin
        mismatch_q <= 1'b1;
      end
    end else if (op_q == flash_pkg::OP_SETTLE && is_check_q &&
                 timer_q >= 16'(COPY_CYCLES - 1)) begin
      cmp_q <= mismatch_q;
    end
  end

  assign o_ready = (op_q == flash_pkg::OP_IDLE);

  // ****************************************
  // Checks
  // ****************************************
  AST_SO_RELEASE:
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    cs_rise |=> o_so_oe_n && src_q == flash_pkg::SRC_NONE)
    else $error("output still driven after chip select rise");

  AST_IGNORE_CLOCK_IDLE:
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    sync_q.cs_n && prev_q.cs_n |=> $stable(bit_cnt_q) && $stable(shift_q))
    else $error("bits taken while chip select high");

  AST_BUSY_HOLDS:
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    start |=> !o_ready [*8])
    else $error("busy not held after operation start");

  // Busy length is far beyond a delay range, so it is counted instead
  logic [15:0] busy_cnt_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_cnt_q <= '0;
    end else if (op_q == flash_pkg::OP_IDLE) begin
      busy_cnt_q <= '0;
    end else begin
      busy_cnt_q <= busy_cnt_q + 16'h0001;
    end
  end

  AST_BUSY_BOUNDED:
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !o_ready |-> busy_cnt_q < 16'(COPY_CYCLES))
    else $error("operation never finished");

  AST_PARTIAL_DROPPED:
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    cs_rise && !addr_done_q && o_ready |=> o_ready)
    else $error("partial instruction started an operation");

  AST_PAGE_WRAP:
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    issue && !cs_rise && !cs_fall && ptr_q == flash_pkg::LAST_BYTE &&
    !(sck_rise && bit_cnt_q == flash_pkg::LAST_ADDR_BIT) |=> ptr_q == 9'h000)
    else $error("read pointer did not wrap to byte zero");

  AST_BUFFER_ONLY_BY_COPY:
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    cs_rise && opcode_q == flash_pkg::OP_PAGE_READ && o_ready |=> o_ready)
    else $error("page read started a buffer update");

  AST_COMPARE_RESULT:
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    op_q == flash_pkg::OP_SETTLE && is_check_q && timer_q >= 16'(COPY_CYCLES - 1)
    |=> status_w[flash_pkg::STAT_CMP_BIT] == $past(mismatch_q) && o_ready)
    else $error("compare outcome not in status");

  AST_MSB_FIRST:
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    sck_fall && src_q != flash_pkg::SRC_NONE && out_cnt_q == 3'h0 && !cs_fall
    |=> o_so == $past(next_byte[7]))
    else $error("first bit of byte is not its MSB");

endmodule

// [spi_host_model.sv]
/*
  Host master model for the serial flash link, in clock mode 0 or 3.
  Assumes the testbench calls its tasks and reads the captured bytes.
*/
`timescale 1ns/1ns

module spi_host_model (
  // Link towards the device
  output flash_pkg::link_t o_link,
  input wire logic i_so,
  input wire logic i_so_oe_n
);
  logic [7:0] got [$];
  logic [7:0] sh;
  logic oe_seen;

  initial begin
    o_link = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
    sh = 8'h00;
    oe_seen = 1'b1;
  end

  // ****************************************
  // One framed instruction
  // ****************************************
  // Header goes out first, then n_rd bytes are read back
  task automatic frame(input logic [63:0] hdr, input int n_hdr, input int n_rd,
                       input bit mode3);
    got.delete();
    o_link.sck = mode3;
    // Odd offset keeps link edges away from the system clock edges
    #87 o_link.cs_n = 1'b0;
    for (int i = 0; i < n_hdr + 8 * n_rd; i++) begin
      o_link.sck = 1'b0;
      o_link.si = (i < n_hdr) ? hdr[n_hdr - 1 - i] : ~o_link.si;
      #80 o_link.sck = 1'b1;
      // Sampled late in the high phase: the device updates up to 60 ns after a fall
      #60 if (i >= n_hdr) begin
        sh = {sh[6:0], i_so};
        oe_seen = i_so_oe_n;
        if ((i - n_hdr) % 8 == 7) got.push_back(sh);
      end
      #20;
    end
    o_link.sck = mode3;
    #80 o_link.cs_n = 1'b1;
    o_link.si = ~o_link.si;
  endtask

  // Clock and data toggling with chip select high
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #80 o_link.sck = ~o_link.sck;
      o_link.si = ~o_link.si;
    end
  endtask
endmodule

// [test_serial_flash_read_command_path.sv]
/*
  Self-checking testbench of the serial flash read command path.
  Assumes the host model file and the design files are compiled first.
*/
`timescale 1ns/1ns

module test_serial_flash_read_command_path;
  localparam int unsigned COPY_N = 600;
  typedef struct packed {
    logic from_buf;
    logic mode3;
    logic [8:0] page;
    logic [8:0] off;
    logic [2:0] n;
  } row_t;

  logic clk;
  logic arst_n;
  flash_pkg::link_t link;
  logic so;
  logic so_oe_n;
  logic ready;
  logic load_valid;
  logic [17:0] load_addr;
  logic [7:0] load_data;
  int bad_count = 0;
  int n_checks = 0;
  row_t rows [6];

  always #10 clk = ~clk;

  serial_flash_read_command_path #(.COPY_CYCLES(COPY_N)) i_dut (
    .i_clk(clk), .i_arst_n(arst_n), .i_cs_n(link.cs_n), .i_sck(link.sck),
    .i_si(link.si), .o_so(so), .o_so_oe_n(so_oe_n), .o_ready(ready),
    .i_load_valid(load_valid), .i_load_addr(load_addr), .i_load_data(load_data));

  spi_host_model i_host (.o_link(link), .i_so(so), .i_so_oe_n(so_oe_n));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] pat(input int unsigned p, input int unsigned o);
    return 8'((p * 37 + o * 5 + 1) % 256);
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic preload(input int unsigned p);
    for (int unsigned o = 0; o < flash_pkg::PAGE_BYTES; o++) begin
      @(posedge clk);
      load_valid <= 1'b1;
      load_addr <= 18'(p * flash_pkg::PAGE_BYTES + o);
      load_data <= pat(p, o);
    end
    @(posedge clk);
    load_valid <= 1'b0;
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 2 * COPY_N) begin
      @(posedge clk);
      k++;
    end
  endtask

  // Copy or compare of one page, then a status byte once idle again
  task automatic page_op(input logic [7:0] op, input logic [8:0] page, input logic cmp);
    i_host.frame(64'({op, 6'h00, page, 9'h000}), 32, 0, 1'b0);
    repeat (8) @(posedge clk);
    check(8'(ready), 8'h00);
    wait_ready();
    check(8'(ready), 8'h01);
    i_host.frame(64'h57, 8, 1, 1'b0);
    check(i_host.got[0], {1'b1, cmp, flash_pkg::DENSITY_CODE, 2'h0});
  endtask

  initial begin
    #400000;
    bad_count++;
    report_and_stop();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    load_valid = 1'b0;
    load_addr = 18'h00000;
    load_data = 8'h00;
    rows[0] = '{1'b0, 1'b0, 9'd1, 9'd0, 3'd3};
    rows[1] = '{1'b0, 1'b1, 9'd511, 9'd262, 3'd4};
    rows[2] = '{1'b1, 1'b0, 9'd1, 9'd263, 3'd3};
    rows[3] = '{1'b0, 1'b1, 9'd0, 9'd5, 3'd2};
    rows[4] = '{1'b1, 1'b1, 9'd1, 9'd10, 3'd2};
    // Seven bytes outrun the prefetch, so the full FIFO must refill on the way
    rows[5] = '{1'b1, 1'b0, 9'd1, 9'd258, 3'd7};
    repeat (3) @(posedge clk);
    check(8'(so_oe_n), 8'h01);
    check(8'(ready), 8'h01);
    arst_n <= 1'b1;
    preload(0);
    preload(1);
    preload(511);
    // Copy page 1; status read while busy shows the busy flag
    i_host.frame(64'({8'h53, 6'h00, 9'd1, 9'h000}), 32, 0, 1'b0);
    repeat (8) @(posedge clk);
    check(8'(ready), 8'h00);
    i_host.frame(64'h57, 8, 1, 1'b0);
    check(i_host.got[0], {2'b00, flash_pkg::DENSITY_CODE, 2'h0});
    // A compare sent while the copy runs must be ignored
    i_host.frame(64'({8'h60, 6'h00, 9'd0, 9'h000}), 32, 0, 1'b0);
    repeat (8) @(posedge clk);
    check(8'(ready), 8'h00);
    wait_ready();
    i_host.frame(64'h57, 8, 2, 1'b1);
    for (int k = 0; k < 2; k++)
      check(i_host.got[k], {2'b10, flash_pkg::DENSITY_CODE, 2'h0});
    for (int r = 0; r < 6; r++) begin
      if (rows[r].from_buf)
        i_host.frame(64'({8'h54, 15'h0, rows[r].off, 8'h00}), 40, rows[r].n, rows[r].mode3);
      else
        i_host.frame({8'h52, 6'h00, rows[r].page, rows[r].off, 32'h0}, 64, rows[r].n,
                     rows[r].mode3);
      for (int k = 0; k < int'(rows[r].n); k++)
        check(i_host.got[k], pat(rows[r].page, (rows[r].off + k) % 264));
      check(8'(i_host.oe_seen), 8'h00);
      repeat (6) @(posedge clk);
      check(8'(so_oe_n), 8'h01);
    end
    // Clock noise with chip select high, then a cut-short copy of page 0
    i_host.idle_clocks(16);
    i_host.frame(64'({8'h53, 6'h00, 9'd0}), 23, 0, 1'b0);
    repeat (12) @(posedge clk);
    check(8'(ready), 8'h01);
    i_host.frame(64'({8'h54, 15'h0, 9'd20, 8'h00}), 40, 1, 1'b0);
    check(i_host.got[0], pat(1, 20));
    page_op(8'h60, 9'd0, 1'b1);
    // Reset in the middle of a compare: busy and the stored result both clear
    i_host.frame(64'({8'h60, 6'h00, 9'd1, 9'h000}), 32, 0, 1'b0);
    repeat (20) @(posedge clk);
    check(8'(ready), 8'h00);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check(8'(ready), 8'h01);
    check(8'(so_oe_n), 8'h01);
    arst_n <= 1'b1;
    i_host.frame(64'h57, 8, 1, 1'b1);
    check(i_host.got[0], {2'b10, flash_pkg::DENSITY_CODE, 2'h0});
    page_op(8'h60, 9'd1, 1'b0);
    report_and_stop();
  end
endmodule
